// [asot_top.sv]
`timescale 1ns/1ps
`default_nettype none

module asot_top
    import asot_pkg::*;
(
    // Clock, reset and freeze
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // System power state
    input wire logic low_power_i,
    // Converter side
    input wire logic cmp_i,
    output logic conv_power_o,
    output logic conv_clk_o,
    output logic sample_o,
    output logic autozero_o,
    output logic result_load_phase_o,
    output logic [9:0] dac_code_o,
    output logic [2:0] channel_o,
    output logic [1:0] mode_o,
    // Amplifier side
    output logic amp_enable_o,
    output logic amp_open_loop_o,
    output logic [2:0] amp_gain_o,
    output logic amp1_enable_o,
    output logic temp_sensor_enable_o,
    output logic n_cal_reference_o,
    output logic p_cal_reference_o,
    output logic mux_disable_o,
    output logic [6:0] n_trim_o,
    output logic [6:0] p_trim_o
);

    typedef struct packed {
        logic conversion_busy;
        logic presc_sel;
        logic [1:0] mode;
        logic [2:0] chan;
        logic result_invalid;
        logic amp1_en;
        logic temp_en;
        logic trim_mode;
        logic [2:0] gain_sel;
        logic [7:0] n_pair_offset;
        logic [7:0] p_pair_offset;
        logic [9:0] result;
        logic [5:0] div_cnt;
        logic tick;
        logic cmp_s1;
        logic cmp_s2;
        logic cmp_s3;
        logic cmp_f;
        logic low_power_q;
        logic [7:0] prdata;
    } asot_top_reg_type;

    asot_top_reg_type q;
    asot_top_reg_type d;

    logic seq_run;
    logic seq_done;
    logic [9:0] seq_result;
    logic wr_en;
    logic [7:0] wdata;
    logic [5:0] div_last;
    logic addr_mapped;

    // ****************************************************************
    // Register read helpers
    // ****************************************************************
    function automatic logic [7:0] ctrl_view(input asot_top_reg_type s);
        logic [7:0] v;
        v = 8'h00;
        v[CTRL_BUSY_BIT] = s.conversion_busy;
        v[CTRL_PRESC_BIT] = s.presc_sel;
        v[CTRL_MODE_LSB +: 2] = s.mode;
        v[CTRL_CHAN_LSB +: 3] = s.chan;
        v[CTRL_INVALID_BIT] = s.result_invalid;
        return v;
    endfunction

    function automatic logic [7:0] gain_view(input asot_top_reg_type s);
        logic [7:0] v;
        v = 8'h00;
        v[GAIN_SEL_LSB +: 3] = s.gain_sel;
        v[GAIN_TRIM_BIT] = s.trim_mode;
        v[GAIN_TS_BIT] = s.temp_en;
        v[GAIN_AMP1_BIT] = s.amp1_en;
        return v;
    endfunction

    function automatic logic [7:0] read_reg(input asot_top_reg_type s,
                                            input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            ASOT_CTRL_OFF: begin
                v = ctrl_view(s);
            end
            ASOT_RES_HI_OFF: begin
                v = s.result[9:2];
            end
            ASOT_RES_LO_OFF: begin
                v = {s.result[1:0], 6'h00};
            end
            ASOT_GAIN_OFF: begin
                v = gain_view(s);
            end
            ASOT_NTRIM_OFF: begin
                v = s.n_pair_offset;
            end
            ASOT_PTRIM_OFF: begin
                v = s.p_pair_offset;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    always_comb begin
        case (paddr_i)
            ASOT_CTRL_OFF, ASOT_RES_HI_OFF, ASOT_RES_LO_OFF,
            ASOT_GAIN_OFF, ASOT_NTRIM_OFF, ASOT_PTRIM_OFF: begin
                addr_mapped = 1'b1;
            end
            default: begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    // A frozen block cannot take a write, so it holds the access phase.
    assign pready_o = clk_en_i;
    assign pslverr_o = psel_i && penable_i && !addr_mapped;
    assign wr_en = psel_i && penable_i && pwrite_i && addr_mapped;
    assign wdata = pwdata_i[7:0];
    assign prdata_o = {24'h000000, q.prdata};
    assign div_last = (q.presc_sel ? PRESC_DIV_HI : PRESC_DIV_LO) - 6'h01;

    // The sequencer stops in low power and restarts from step zero.
    assign seq_run = q.conversion_busy && !q.low_power_q;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.tick = 1'b0;

        // Comparator pin: three stages, a change needs two agreeing.
        d.cmp_s1 = cmp_i;
        d.cmp_s2 = q.cmp_s1;
        d.cmp_s3 = q.cmp_s2;
        if (q.cmp_s2 == q.cmp_s3) begin
            d.cmp_f = q.cmp_s3;
        end

        d.low_power_q = low_power_i;

        // Read data is captured while selected, ready for the access.
        if (psel_i) begin
            d.prdata = read_reg(q, paddr_i);
        end

        // Converter clock runs only for a live conversion.
        if (seq_run) begin
            if (q.div_cnt == div_last) begin
                d.div_cnt = 6'h00;
                d.tick = 1'b1;
            end else begin
                d.div_cnt = q.div_cnt + 6'h01;
            end
        end else begin
            d.div_cnt = 6'h00;
        end

        // Completion: the whole result moves at once.
        if (seq_done) begin
            d.conversion_busy = 1'b0;
            d.result = seq_result;
        end

        if (wr_en) begin
            case (paddr_i)
                ASOT_CTRL_OFF: begin
                    if (q.conversion_busy) begin
                        // Only an abort gets through while converting.
                        if (!wdata[CTRL_BUSY_BIT]) begin
                            d.conversion_busy = 1'b0;
                        end
                    end else begin
                        // One write may reload prescaler, mode and channel and start.
                        d.presc_sel = wdata[CTRL_PRESC_BIT];
                        d.mode = wdata[CTRL_MODE_LSB +: 2];
                        d.chan = wdata[CTRL_CHAN_LSB +: 3];
                        d.conversion_busy = wdata[CTRL_BUSY_BIT];
                        if (wdata[CTRL_BUSY_BIT]) begin
                            d.result_invalid = 1'b0;
                            d.div_cnt = 6'h00;
                        end
                    end
                end
                ASOT_GAIN_OFF: begin
                    d.gain_sel = wdata[GAIN_SEL_LSB +: 3];
                    d.trim_mode = wdata[GAIN_TRIM_BIT];
                    d.temp_en = wdata[GAIN_TS_BIT];
                    d.amp1_en = wdata[GAIN_AMP1_BIT];
                end
                ASOT_NTRIM_OFF: begin
                    d.n_pair_offset = wdata;
                end
                ASOT_PTRIM_OFF: begin
                    d.p_pair_offset = wdata;
                end
                default: begin
                    d.prdata = q.prdata;
                end
            endcase
        end

        // Entering low power mid-conversion spoils the sample; this set
        // is placed after the write so that it wins over a clear.
        if (low_power_i && !q.low_power_q && q.conversion_busy
                && !seq_done) begin
            d.result_invalid = 1'b1;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.conversion_busy <= CTRL_RESET[CTRL_BUSY_BIT];
            q.gain_sel <= GAIN_RESET[GAIN_SEL_LSB +: 3];
            q.n_pair_offset <= TRIM_RESET;
            q.p_pair_offset <= TRIM_RESET;
            q.result <= RESULT_RESET;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    // There is no separate debug-halt input: the freeze input clk_en_i
    // also stops the sequencer, so a frozen conversion resumes where it left off.
    asot_sar_seq u_seq (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .conv_tick_i(q.tick),
        .run_i(seq_run),
        .cmp_i(q.cmp_f),
        .sample_o(sample_o),
        .autozero_o(autozero_o),
        .load_o(result_load_phase_o),
        .dac_code_o(dac_code_o),
        .done_o(seq_done),
        .result_o(seq_result)
    );

    // ****************************************************************
    // Analog controls
    // ****************************************************************
    assign conv_power_o = seq_run;
    assign conv_clk_o = q.tick;
    assign channel_o = q.chan;
    assign mode_o = q.mode;
    assign amp_open_loop_o = q.trim_mode;
    assign amp_enable_o = q.trim_mode || (q.gain_sel != 3'h0);
    assign amp_gain_o = q.gain_sel;
    assign amp1_enable_o = q.amp1_en;
    assign temp_sensor_enable_o = q.temp_en;
    assign n_cal_reference_o = q.n_pair_offset[TRIM_REF_BIT];
    assign p_cal_reference_o = q.p_pair_offset[TRIM_REF_BIT];
    assign mux_disable_o = q.n_pair_offset[TRIM_REF_BIT]
        || q.p_pair_offset[TRIM_REF_BIT];
    assign n_trim_o = q.n_pair_offset[TRIM_SIGN_BIT:0];
    assign p_trim_o = q.p_pair_offset[TRIM_SIGN_BIT:0];

endmodule

`default_nettype wire

// [asot_pkg.sv]
`default_nettype none

package asot_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] ASOT_CTRL_OFF = 8'h00;
    localparam logic [7:0] ASOT_RES_HI_OFF = 8'h04;
    localparam logic [7:0] ASOT_RES_LO_OFF = 8'h08;
    localparam logic [7:0] ASOT_GAIN_OFF = 8'h0C;
    localparam logic [7:0] ASOT_NTRIM_OFF = 8'h10;
    localparam logic [7:0] ASOT_PTRIM_OFF = 8'h14;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_BUSY_BIT = 0;
    localparam int CTRL_PRESC_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_CHAN_LSB = 4;
    localparam int CTRL_INVALID_BIT = 7;
    localparam int GAIN_SEL_LSB = 0;
    localparam int GAIN_TRIM_BIT = 5;
    localparam int GAIN_TS_BIT = 6;
    localparam int GAIN_AMP1_BIT = 7;
    localparam int TRIM_SIGN_BIT = 6;
    localparam int TRIM_REF_BIT = 7;
    localparam int RES_LO_SHIFT = 6;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // ****************************************************************
    // Converter clock and conversion timing
    // ****************************************************************
    localparam logic [5:0] PRESC_DIV_LO = 6'h10;
    localparam logic [5:0] PRESC_DIV_HI = 6'h20;
    localparam logic [3:0] SEQ_SAMPLE_CYCLES = 4'h3;
    localparam logic [3:0] SEQ_AZ_STEP = SEQ_SAMPLE_CYCLES;
    localparam logic [3:0] SEQ_BIT_CYCLES = 4'hA;
    localparam logic [3:0] SEQ_FIRST_BIT_STEP = 4'h4;
    localparam logic [3:0] SEQ_LOAD_STEP = 4'hE;
    localparam logic [9:0] SEQ_MSB_TRIAL = 10'h200;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_RUN,
        SEQ_HOLD
    } asot_seq_state_type;

endpackage

`default_nettype wire

// [asot_sar_seq.sv]
`timescale 1ns/1ps
`default_nettype none

module asot_sar_seq
    import asot_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    // Control from the register side
    input wire logic conv_tick_i,
    input wire logic run_i,
    input wire logic cmp_i,
    // Converter timing and result
    output logic sample_o,
    output logic autozero_o,
    output logic load_o,
    output logic [9:0] dac_code_o,
    output logic done_o,
    output logic [9:0] result_o
);

    typedef struct packed {
        asot_seq_state_type state;
        logic [3:0] step;
        logic [9:0] sar;
        logic [9:0] trial;
        logic [9:0] result;
        logic done;
    } asot_seq_reg_type;

    asot_seq_reg_type q;
    asot_seq_reg_type d;

    // ****************************************************************
    // Fifteen-step conversion sequence
    // ****************************************************************
    always_comb begin
        d = q;
        d.done = 1'b0;
        if (!run_i) begin
            // Dropping run aborts or powers down; the next run starts over.
            d.state = SEQ_IDLE;
            d.step = 4'h0;
        end else begin
            case (q.state)
                SEQ_IDLE: begin
                    if (conv_tick_i) begin
                        d.state = SEQ_RUN;
                        d.step = 4'h0;
                        d.sar = 10'h000;
                        d.trial = 10'h000;
                    end
                end
                SEQ_RUN: begin
                    if (conv_tick_i) begin
                        d.step = q.step + 4'h1;
                        if (q.step == SEQ_LOAD_STEP) begin
                            d.result = q.sar;
                            d.done = 1'b1;
                            d.state = SEQ_HOLD;
                        end else if (q.step == SEQ_AZ_STEP) begin
                            d.trial = SEQ_MSB_TRIAL;
                            d.sar = SEQ_MSB_TRIAL;
                        end else if (q.step >= SEQ_FIRST_BIT_STEP) begin
                            d.sar = cmp_i ? q.sar : (q.sar & ~q.trial);
                            d.trial = q.trial >> 1;
                            d.sar = d.sar | d.trial;
                        end
                    end
                end
                SEQ_HOLD: begin
                    // Waits here until the busy flag has been cleared.
                    d.state = SEQ_HOLD;
                end
                default: begin
                    d.state = SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.state <= SEQ_IDLE;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    assign sample_o = (q.state == SEQ_RUN) && (q.step < SEQ_AZ_STEP);
    assign autozero_o = (q.state == SEQ_RUN) && (q.step == SEQ_AZ_STEP);
    assign load_o = (q.state == SEQ_RUN) && (q.step == SEQ_LOAD_STEP);
    assign dac_code_o = q.sar;
    assign done_o = q.done;
    assign result_o = q.result;

endmodule

`default_nettype wire

// [asot_chk.sv]
`timescale 1ns/1ps
`default_nettype none

// ******
// Port checks
// ******
module asot_chk
    import asot_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Bus and power
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic low_power_i,
    // Converter and amplifier
    input wire logic conv_power_o,
    input wire logic conv_clk_o,
    input wire logic sample_o,
    input wire logic autozero_o,
    input wire logic result_load_phase_o,
    input wire logic [2:0] channel_o,
    input wire logic [1:0] mode_o,
    input wire logic amp_enable_o,
    input wire logic amp_open_loop_o,
    input wire logic mux_disable_o,
    input wire logic n_cal_reference_o,
    input wire logic p_cal_reference_o,
    input wire logic [6:0] n_trim_o
);
    logic [2:0] samp_cnt_q;
    logic [4:0] pulse_cnt_q;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    // Counters stand in for repetitions far longer than eight cycles.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            samp_cnt_q <= 3'h0;
            pulse_cnt_q <= 5'h00;
        end else begin
            samp_cnt_q <= sample_o ? samp_cnt_q + 3'(conv_clk_o) : 3'h0;
            pulse_cnt_q <= conv_power_o ? pulse_cnt_q + 5'(conv_clk_o)
                                        : 5'h00;
        end
    end

    sequence seq_sample_end;
        $fell(sample_o) && conv_power_o;
    endsequence

    sequence seq_load_end;
        $fell(result_load_phase_o) && !low_power_i;
    endsequence

    AST_OPEN_LOOP_ON:
        assert property (amp_open_loop_o |-> amp_enable_o)
        else $error("open loop without amplifier enable");
    AST_MUX_OFF:
        assert property (mux_disable_o == (n_cal_reference_o
                         || p_cal_reference_o))
        else $error("mux disable does not follow reference selects");
    AST_IDLE_GATED:
        assert property (!conv_power_o && !$past(conv_power_o)
            && !low_power_i && !$past(low_power_i)
            |-> !conv_clk_o && !sample_o)
        else $error("converter clocked while idle");
    AST_SAMPLE_THREE:
        assert property (seq_sample_end |-> samp_cnt_q == 3'h3)
        else $error("sample did not span three converter clocks");
    AST_AZ_AFTER_SAMPLE:
        assert property (seq_sample_end |-> autozero_o)
        else $error("auto-zero does not follow sampling");
    AST_SEQ_BOUND:
        assert property (pulse_cnt_q <= 5'h10)
        else $error("conversion ran past its steps");
    AST_LOAD_DONE:
        assert property (seq_load_end |-> ##[0:2] !conv_power_o)
        else $error("busy not cleared after load phase");
    AST_CTRL_LOCK:
        assert property (conv_power_o && $past(conv_power_o)
            |-> $stable(channel_o) && $stable(mode_o))
        else $error("control field changed during conversion");
    AST_NTRIM_WRITE:
        assert property ($changed(n_trim_o) |-> $past(psel_i)
            && $past(penable_i) && $past(pwrite_i)
            && $past(paddr_i) == ASOT_NTRIM_OFF)
        else $error("trim changed without a write");
endmodule

bind asot_top asot_chk u_chk (.core_clk_i, .rstn_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .low_power_i, .conv_power_o,
    .conv_clk_o, .sample_o, .autozero_o, .result_load_phase_o,
    .channel_o, .mode_o, .amp_enable_o, .amp_open_loop_o,
    .mux_disable_o, .n_cal_reference_o, .p_cal_reference_o, .n_trim_o);

`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none

// ******
// Register-level tests
// ******
module tb
    import asot_pkg::*;
;
    logic core_clk_i, rstn_i, clk_en_i, psel_i, penable_i, pwrite_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rdat;
    logic pready_o, pslverr_o, low_power_i, cmp_i, conv_power_o, err;
    logic conv_clk_o, sample_o, autozero_o, result_load_phase_o;
    logic [2:0] channel_o;
    logic [1:0] mode_o;
    logic amp_enable_o, amp_open_loop_o, mux_disable_o;
    logic n_cal_reference_o, p_cal_reference_o;
    logic [6:0] n_trim_o, p_trim_o;
    logic [9:0] dac_code_o;
    logic [2:0] amp_gain_o;
    logic amp1_enable_o, temp_sensor_enable_o;
    logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    int bad_count, checks;
    // Offsets that the comparator model hides in each input pair.
    localparam logic [5:0] OFS_N = 6'h2B;
    localparam logic [5:0] OFS_P = 6'h15;
    // No amplifier is modelled, so the settling wait is cut short.
    localparam int SETTLE_CYCLES = 50;

    asot_top DUT (.core_clk_i, .rstn_i, .clk_en_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .low_power_i, .cmp_i, .conv_power_o, .conv_clk_o, .sample_o,
        .autozero_o, .result_load_phase_o, .dac_code_o, .channel_o,
        .mode_o, .amp_enable_o, .amp_open_loop_o, .amp_gain_o,
        .amp1_enable_o, .temp_sensor_enable_o, .n_cal_reference_o,
        .p_cal_reference_o, .mux_disable_o, .n_trim_o, .p_trim_o);

    always #4 core_clk_i = ~core_clk_i;

    task automatic close_out();
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // The #1 at the end lets callers look at outputs the write updated.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic e);
        int n;
        n = 0;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= {24'h000000, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20)
            check(32'h0, 32'h1);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rdat, err);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00, rdat, err);
        check(rdat, exp);
    endtask

    // Counts converter clocks from the start of sampling until idle.
    task automatic conv_watch(input int gap_exp);
        int n, last, pulses;
        logic seen;
        n = 0;
        last = 0;
        pulses = 0;
        seen = 1'b0;
        while (n < 1200 && !(seen && conv_power_o === 1'b0)) begin
            @(posedge core_clk_i);
            n++;
            if (sample_o === 1'b1)
                seen = 1'b1;
            if (seen && conv_clk_o === 1'b1) begin
                if (pulses > 0)
                    check(32'(n - last), 32'(gap_exp));
                last = n;
                pulses++;
            end
        end
        check(32'(pulses), 32'd15);
    endtask

    // Sets the comparator from the trim in force, settles, converts.
    task automatic measure(input logic [7:0] a, output logic [2:0] top);
        @(posedge core_clk_i);
        if (a == ASOT_PTRIM_OFF)
            cmp_i <= (p_trim_o[5:0] > OFS_P);
        else
            cmp_i <= (n_trim_o[5:0] <= OFS_N);
        repeat (SETTLE_CYCLES) @(posedge core_clk_i);
        wr(ASOT_CTRL_OFF, 8'h01);
        do begin
            apb(1'b0, ASOT_CTRL_OFF, 8'h00, rdat, err);
        end while (rdat[CTRL_BUSY_BIT] !== 1'b0);
        apb(1'b0, ASOT_RES_HI_OFF, 8'h00, rdat, err);
        top = rdat[7:5];
    endtask

    // Software search of one input pair, then a read-back.
    task automatic trim_pair(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic [2:0] top;
        logic stop;
        int b;
        v = 8'hC0;
        stop = 1'b0;
        wr(a, v);
        measure(a, top);
        if (top == 3'h0)
            v[TRIM_SIGN_BIT] = 1'b0;
        else if (top != 3'h7)
            stop = 1'b1;
        for (b = 5; b >= 0 && !stop; b--) begin
            v[b] = 1'b1;
            wr(a, v);
            measure(a, top);
            if (top == {3{~v[TRIM_SIGN_BIT]}})
                v[b] = 1'b0;
            else if (top != {3{v[TRIM_SIGN_BIT]}})
                stop = 1'b1;
        end
        v[TRIM_REF_BIT] = 1'b0;
        wr(a, v);
        rd_chk(a, {24'h000000, exp});
    endtask

    initial begin
        repeat (20000) @(posedge core_clk_i);
        bad_count++;
        close_out();
    end

    initial begin
        core_clk_i = 1'b0;
        rstn_i = 1'b0;
        clk_en_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        low_power_i = 1'b0;
        cmp_i = 1'b1;
        bad_count = 0;
        checks = 0;
        repeat (6) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        foreach (offs[i]) rd_chk(offs[i], 32'h0);
        apb(1'b0, 8'h18, 8'h00, rdat, err);
        check(rdat, 32'h0);
        check({31'h0, err}, 32'h1);
        wr(ASOT_GAIN_OFF, 8'hFF);
        check({amp1_enable_o, temp_sensor_enable_o, amp_gain_o}, 32'h1F);
        rd_chk(ASOT_GAIN_OFF, 32'hE7);
        wr(ASOT_GAIN_OFF, 8'h20);
        check({amp_enable_o, amp_open_loop_o}, 32'h3);
        wr(ASOT_GAIN_OFF, 8'h00);
        check({31'h0, amp_open_loop_o}, 32'h0);
        wr(ASOT_NTRIM_OFF, 8'hC0);
        rd_chk(ASOT_NTRIM_OFF, 32'hC0);
        check({n_cal_reference_o, mux_disable_o}, 32'h3);
        check({25'h0, n_trim_o}, 32'h40);
        wr(ASOT_NTRIM_OFF, 8'h5A);
        check({n_cal_reference_o, mux_disable_o}, 32'h0);
        check({25'h0, n_trim_o}, 32'h5A);
        wr(ASOT_PTRIM_OFF, 8'hC0);
        check({p_cal_reference_o, mux_disable_o}, 32'h3);
        wr(ASOT_PTRIM_OFF, 8'h3F);
        check({p_cal_reference_o, p_trim_o}, 32'h3F);
        @(posedge core_clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        rd_chk(ASOT_NTRIM_OFF, 32'h0);
        rd_chk(ASOT_PTRIM_OFF, 32'h0);
        wr(ASOT_CTRL_OFF, 8'h01);
        check({31'h0, conv_power_o}, 32'h1);
        conv_watch(int'(PRESC_DIV_LO));
        check({22'h0, dac_code_o}, 32'h3FF);
        rd_chk(ASOT_CTRL_OFF, 32'h00);
        rd_chk(ASOT_RES_HI_OFF, 32'hFF);
        rd_chk(ASOT_RES_LO_OFF, 32'hC0);
        wr(ASOT_CTRL_OFF, 8'h25);
        check({channel_o, mode_o}, 32'h09);
        wr(ASOT_CTRL_OFF, 8'hF3);
        rd_chk(ASOT_CTRL_OFF, 32'h25);
        check({channel_o, mode_o}, 32'h09);
        wr(ASOT_CTRL_OFF, 8'h00);
        check({31'h0, conv_power_o}, 32'h0);
        rd_chk(ASOT_RES_HI_OFF, 32'hFF);
        @(posedge core_clk_i);
        cmp_i <= 1'b0;
        wr(ASOT_CTRL_OFF, 8'h7B);
        check({channel_o, mode_o}, 32'h1E);
        conv_watch(int'(PRESC_DIV_HI));
        rd_chk(ASOT_CTRL_OFF, 32'h7A);
        rd_chk(ASOT_RES_HI_OFF, 32'h00);
        rd_chk(ASOT_RES_LO_OFF, 32'h00);
        wr(ASOT_CTRL_OFF, 8'h01);
        repeat (100) @(posedge core_clk_i);
        low_power_i <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        check({conv_power_o, sample_o}, 32'h0);
        low_power_i <= 1'b0;
        conv_watch(int'(PRESC_DIV_LO));
        rd_chk(ASOT_CTRL_OFF, 32'h80);
        wr(ASOT_GAIN_OFF, 8'h20);
        trim_pair(ASOT_NTRIM_OFF, {2'b01, OFS_N});
        trim_pair(ASOT_PTRIM_OFF, {2'b00, OFS_P});
        wr(ASOT_GAIN_OFF, 8'h00);
        check({n_trim_o, p_trim_o}, {1'b1, OFS_N, 1'b0, OFS_P});
        close_out();
    end
endmodule

`default_nettype wire
